// ==== core/otc_pkg.sv ====
// Purpose: Shared constants, types and register map for the oscillator trim and clock-out block.
// Assumes: Registers sit at printed word indices; byte address is four times the index.
// Notes:   All reset values and field positions live here so the modules carry no bare numbers.
package otc_pkg;

    // ------------------------------------------------------------------
    // Register indices and bus geometry
    // ------------------------------------------------------------------
    localparam int unsigned OTC_ADDR_W = 18;
    localparam logic [15:0] OTC_IDX_COARSE = 16'hA001;
    localparam logic [15:0] OTC_IDX_FINE = 16'hA002;
    localparam logic [15:0] OTC_IDX_SWEPT = 16'hA003;
    localparam logic [15:0] OTC_IDX_CLOCK_OUTPUT_CONTROL = 16'hA006;
    localparam logic [15:0] OTC_IDX_SLOW = 16'hA007;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] OTC_RST_COARSE = 8'h01;
    localparam logic [7:0] OTC_RST_FINE = 8'h80;
    localparam logic [7:0] OTC_RST_CLOCK_OUTPUT_CONTROL = 8'h00;
    localparam logic [4:0] OTC_RST_SLOW = 5'h08;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned OTC_INTERVAL_LSB = 4;
    localparam int unsigned OTC_AMP_LSB = 2;
    localparam int unsigned OTC_COARSE_LSB = 0;
    localparam int unsigned OTC_CKO_EN_BIT = 7;
    localparam int unsigned OTC_CKO_SEL_LSB = 5;
    localparam int unsigned OTC_CKO_DIV_LSB = 0;
    localparam int unsigned OTC_SLOW_SEL_BIT = 4;
    localparam int unsigned OTC_SLOW_TRIM_LSB = 0;

    // Last slow counter value in each 32 kHz tick period (four and eight base edges), for the 128 kHz and 256 kHz centres.
    localparam logic [2:0] OTC_SLOW_LAST_128 = 3'h3;
    localparam logic [2:0] OTC_SLOW_LAST_256 = 3'h7;

    // Sweep amplitude per code; code 01 is eight steps, the others are a design table.
    localparam logic [3:0][7:0] OTC_AMP_TABLE = {8'h20, 8'h10, 8'h08, 8'h04};

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OTC_SRC_SYS,
        OTC_SRC_FAST,
        OTC_SRC_SLOW,
        OTC_SRC_RSVD
    } otc_src_e;

    typedef enum logic [2:0] {
        OTC_REG_NONE,
        OTC_REG_COARSE,
        OTC_REG_FINE,
        OTC_REG_SWEPT,
        OTC_REG_CLOCK_OUTPUT_CONTROL,
        OTC_REG_SLOW
    } otc_reg_e;

    typedef struct packed {
        logic read;
        logic write;
        logic [OTC_ADDR_W-1:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } otc_avs_req_s;

    typedef struct packed {
        logic [3:0] interval;
        logic [1:0] amp_code;
        logic [7:0] fine;
    } otc_sweep_cfg_s;

    typedef struct packed {
        logic enable;
        otc_src_e source;
        logic [4:0] divider;
    } otc_cko_cfg_s;

endpackage

// ==== core/otc_sweep.sv ====
// Purpose: Spread-spectrum sweep of the fast oscillator fine trim, with clipping.
// Assumes: clock is the fast oscillator clock; configuration is synchronous to it.
// Notes:   Offset moves every second interval and dwells one slot at each extreme.
`timescale 1ns/1ps
module otc_sweep
    import otc_pkg::*;
#(
    parameter int unsigned INTERVAL_W = 4
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire otc_sweep_cfg_s cfg,
    output logic [7:0] swept_trim_output
);

    if (INTERVAL_W != 4) begin : g_chk
        $error("otc_sweep supports only a 4-bit interval field.");
    end

    typedef struct packed {
        logic [3:0] div_cnt;
        logic half;
        logic [8:0] offset;
        logic dir_up;
        logic [1:0] amp_q;
        logic [7:0] trim;
    } otc_sweep_st_s;

    otc_sweep_st_s s;
    otc_sweep_st_s next_s;
    logic [7:0] amp;
    logic [9:0] sum;

    // ------------------------------------------------------------------
    // Sweep stepping and clipping
    // ------------------------------------------------------------------
    // A changed amplitude restarts the sweep so the offset never sits outside the new span.
    always_comb begin
        next_s = s;
        amp = OTC_AMP_TABLE[s.amp_q];
        if (cfg.interval == 4'h0 || cfg.amp_code != s.amp_q) begin
            next_s.div_cnt = 4'h0;
            next_s.half = 1'b0;
            next_s.offset = 9'h000;
            next_s.dir_up = 1'b1;
            next_s.amp_q = cfg.amp_code;
        end else if (s.div_cnt >= cfg.interval - 4'h1) begin
            next_s.div_cnt = 4'h0;
            next_s.half = ~s.half;
            if (s.half) begin
                if (s.dir_up) begin
                    if ($signed(s.offset) >= $signed({1'b0, amp})) begin
                        next_s.dir_up = 1'b0;
                    end else begin
                        next_s.offset = s.offset + 9'h001;
                    end
                end else begin
                    if ($signed(s.offset) <= -$signed({1'b0, amp})) begin
                        next_s.dir_up = 1'b1;
                    end else begin
                        next_s.offset = s.offset - 9'h001;
                    end
                end
            end
        end else begin
            next_s.div_cnt = s.div_cnt + 4'h1;
        end
        sum = {2'b00, cfg.fine} + {next_s.offset[8], next_s.offset};
        if (sum[9]) begin
            next_s.trim = 8'h00;
        end else if (sum[8]) begin
            next_s.trim = 8'hFF;
        end else begin
            next_s.trim = sum[7:0];
        end
    end

    // Synchronous reset puts the sweep at zero offset, moving upward.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s <= '{4'h0, 1'b0, 9'h000, 1'b1, 2'b00, OTC_RST_FINE};
        end else begin
            s <= next_s;
        end
    end

    assign swept_trim_output = s.trim;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_bypass;
        @(posedge clock) disable iff (!rst_n)
        (cfg.interval == 4'h0) |=> (swept_trim_output == $past(cfg.fine));
    endproperty
    a_bypass: assert property (p_bypass) else $error("Trim not passed through with sweep off.");

    property p_interval;
        @(posedge clock) disable iff (!rst_n)
        (cfg.interval != 4'h0 && cfg.amp_code == s.amp_q && s.div_cnt < cfg.interval - 4'h1)
        |=> (s.offset == $past(s.offset));
    endproperty
    a_interval: assert property (p_interval) else $error("Offset moved off interval.");

    property p_amp01;
        @(posedge clock) disable iff (!rst_n)
        (s.amp_q == 2'b01) |-> ($signed(s.offset) <= 9'sd8 && $signed(s.offset) >= -9'sd8);
    endproperty
    a_amp01: assert property (p_amp01) else $error("Code 01 deviation exceeds eight.");

    property p_clip_low;
        @(posedge clock) disable iff (!rst_n)
        (cfg.fine == 8'h00 && $past(cfg.fine) == 8'h00) |-> (swept_trim_output <= amp);
    endproperty
    a_clip_low: assert property (p_clip_low) else $error("Sweep wrapped below zero.");

    property p_clip_high;
        @(posedge clock) disable iff (!rst_n)
        (cfg.fine == 8'hFF && $past(cfg.fine) == 8'hFF) |-> (swept_trim_output >= 8'hFF - amp);
    endproperty
    a_clip_high: assert property (p_clip_high) else $error("Sweep wrapped above 255.");

endmodule

// ==== core/otc_clock_output_control.sv ====
// Purpose: Clock output source selection and divide by divider plus one.
// Assumes: Fast and slow sources arrive as levels synchronous to clock.
// Notes:   A divider of zero on the system clock gives a steady high level.
`timescale 1ns/1ps
module otc_clock_output_control
    import otc_pkg::*;
#(
    parameter int unsigned DIV_W = 5
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire otc_cko_cfg_s cfg,
    input wire logic fast_osc_ref,
    input wire logic slow_tick_32k,
    output logic clock_out
);

    if (DIV_W != 5) begin : g_chk
        $error("otc_clock_output_control supports only a 5-bit divider field.");
    end

    typedef struct packed {
        logic fast_q;
        logic slow_q;
        logic [4:0] cnt;
        logic out;
    } otc_cko_st_s;

    otc_cko_st_s s;
    otc_cko_st_s next_s;
    logic src_event;

    // ------------------------------------------------------------------
    // Source event and divider
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.fast_q = fast_osc_ref;
        next_s.slow_q = slow_tick_32k;
        unique case (cfg.source)
            OTC_SRC_FAST: src_event = fast_osc_ref & ~s.fast_q;
            OTC_SRC_SLOW: src_event = slow_tick_32k & ~s.slow_q;
            OTC_SRC_SYS, OTC_SRC_RSVD: src_event = 1'b1;
        endcase
        if (!cfg.enable) begin
            // Parked at the top so the first event after enable starts a full period at zero.
            next_s.cnt = '1;
            next_s.out = 1'b0;
        end else begin
            if (src_event) begin
                next_s.cnt = (s.cnt >= cfg.divider) ? 5'h00 : s.cnt + 5'h01;
            end
            next_s.out = (next_s.cnt <= (cfg.divider >> 1));
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s <= '{1'b0, 1'b0, 5'h00, 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign clock_out = s.out;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic [5:0] gap;
    logic seen_rise;

    // Helper: cycles since the last rising edge of the output.
    always_ff @(posedge clock) begin
        if (!rst_n || !cfg.enable) begin
            gap <= 6'h00;
            seen_rise <= 1'b0;
        end else if (next_s.out && !s.out) begin
            gap <= 6'h01;
            seen_rise <= 1'b1;
        end else begin
            gap <= gap + 6'h01;
        end
    end

    property p_off;
        @(posedge clock) disable iff (!rst_n)
        !cfg.enable |=> !clock_out;
    endproperty
    a_off: assert property (p_off) else $error("Clock output active while disabled.");

    property p_div;
        @(posedge clock) disable iff (!rst_n)
        (cfg.enable && seen_rise && $stable(cfg.divider) && $stable(cfg.source)
            && (cfg.source == OTC_SRC_SYS || cfg.source == OTC_SRC_RSVD)
            && next_s.out && !s.out)
        |-> (gap == {1'b0, cfg.divider} + 6'h01);
    endproperty
    a_div: assert property (p_div) else $error("Output period is not divider plus one.");

endmodule

// ==== core/otc_top.sv ====
// Purpose: Oscillator trim, spread-spectrum sweep and clock output control behind Avalon-MM.
// Assumes: clock is the fast oscillator clock; oscillator status levels are synchronous.
// Notes:   Every access takes one wait cycle; unmapped words read zero, writes dropped.
//
// Summary of operation
// - Zero interval disables sweep, trim passes through.
// - Swept trim spans fine trim plus/minus amplitude.
// - Interval sets oscillator cycles between sweep updates; offset moves every second interval.
// - Full sweep lasts four times interval times span.
// - Amplitude code 01 deviates eight trim steps.
// - Swept trim saturates between zero and 255.
// - Fast oscillator stands by during stop/sleep.
// - Two-bit coarse field picks oscillator frequency range.
// - Select bit centres slow oscillator; resets clear.
// - Provide 128 kHz base and 32 kHz tick.
// - Slow oscillator is never powered down.
// - Clear enable disables output; set enables divider.
// - Source select: system, fast, slow; 11 system.
// - Output equals source divided by divider plus one.
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module otc_top
    import otc_pkg::*;
#(
    parameter int unsigned DIV_W = 5,
    parameter int unsigned INTERVAL_W = 4
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire otc_avs_req_s avs_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic cpu_stop,
    input wire logic cpu_sleep,
    input wire logic fast_osc_ref,
    input wire logic slow_osc_base,
    output logic fast_osc_run,
    output logic [1:0] coarse_range_trim,
    output logic [7:0] swept_trim_output,
    output logic slow_osc_power,
    output logic slow_freq_select,
    output logic [3:0] slow_osc_trim_value,
    output logic slow_tick_32k,
    output logic clock_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] coarse;
        logic [7:0] fine;
        logic [7:0] clock_output_control;
        logic [4:0] slow;
        logic ack;
        logic [31:0] readdata;
        logic base_q;
        logic [2:0] slow_cnt;
        logic slow_tick;
        logic run;
    } otc_top_st_s;

    otc_top_st_s s;
    otc_top_st_s next_s;
    otc_sweep_cfg_s sweep_cfg;
    otc_cko_cfg_s cko_cfg;
    otc_reg_e sel;
    logic req;
    logic wr_take;
    logic [2:0] slow_last;

    // Decode a byte address into one of the mapped words.
    function automatic otc_reg_e decode(input logic [OTC_ADDR_W-1:0] addr);
        logic [15:0] idx;
        idx = addr[OTC_ADDR_W-1:2];
        if (idx == OTC_IDX_COARSE) begin
            decode = OTC_REG_COARSE;
        end else if (idx == OTC_IDX_FINE) begin
            decode = OTC_REG_FINE;
        end else if (idx == OTC_IDX_SWEPT) begin
            decode = OTC_REG_SWEPT;
        end else if (idx == OTC_IDX_CLOCK_OUTPUT_CONTROL) begin
            decode = OTC_REG_CLOCK_OUTPUT_CONTROL;
        end else if (idx == OTC_IDX_SLOW) begin
            decode = OTC_REG_SLOW;
        end else begin
            decode = OTC_REG_NONE;
        end
    endfunction

    // Read multiplexer; narrow registers sit in the low bits.
    function automatic logic [31:0] read_word(input otc_reg_e r, input otc_top_st_s st,
                                              input logic [7:0] swept);
        unique case (r)
            OTC_REG_COARSE: read_word = {24'h000000, st.coarse};
            OTC_REG_FINE: read_word = {24'h000000, st.fine};
            OTC_REG_SWEPT: read_word = {24'h000000, swept};
            OTC_REG_CLOCK_OUTPUT_CONTROL: read_word = {24'h000000, st.clock_output_control};
            OTC_REG_SLOW: read_word = {27'h0000000, st.slow};
            default: read_word = 32'h00000000;
        endcase
    endfunction

    if (DIV_W != 5 || INTERVAL_W != 4) begin : g_chk
        $error("otc_top supports only the documented field widths.");
    end

    // ------------------------------------------------------------------
    // Bus slave handshake
    // ------------------------------------------------------------------
    // The first cycle of any request is always stalled so read data can come from a flop.
    assign req = avs_req.read | avs_req.write;
    assign avs_waitrequest = req & ~s.ack;
    assign wr_take = avs_req.write & s.ack & avs_req.byteenable[0];
    assign sel = decode(avs_req.address);
    assign slow_last = s.slow[OTC_SLOW_SEL_BIT] ? OTC_SLOW_LAST_256 : OTC_SLOW_LAST_128;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.ack = req & ~s.ack;
        if (req && !s.ack) begin
            next_s.readdata = read_word(sel, s, swept_trim_output);
        end
        // Register writes land on the edge where waitrequest is seen low.
        if (wr_take) begin
            unique case (sel)
                OTC_REG_COARSE: next_s.coarse = avs_req.writedata[7:0];
                OTC_REG_FINE: next_s.fine = avs_req.writedata[7:0];
                OTC_REG_CLOCK_OUTPUT_CONTROL: next_s.clock_output_control = avs_req.writedata[7:0];
                OTC_REG_SLOW: next_s.slow = avs_req.writedata[4:0];
                default: next_s.slow = s.slow;
            endcase
        end
        next_s.base_q = slow_osc_base;
        if (slow_osc_base && !s.base_q) begin
            next_s.slow_cnt = (s.slow_cnt >= slow_last) ? 3'h0 : s.slow_cnt + 3'h1;
        end
        next_s.slow_tick = s.slow[OTC_SLOW_SEL_BIT] ? next_s.slow_cnt[2] : next_s.slow_cnt[1];
        next_s.run = ~(cpu_stop | cpu_sleep);
    end

    // Synchronous reset loads the documented register values.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s <= '{OTC_RST_COARSE, OTC_RST_FINE, OTC_RST_CLOCK_OUTPUT_CONTROL, OTC_RST_SLOW, 1'b0,
                   32'h00000000, 1'b0, 3'h0, 1'b0, 1'b1};
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs and configuration
    // ------------------------------------------------------------------
    assign avs_readdata = s.readdata;
    assign fast_osc_run = s.run;
    assign coarse_range_trim = s.coarse[OTC_COARSE_LSB +: 2];
    assign slow_freq_select = s.slow[OTC_SLOW_SEL_BIT];
    assign slow_osc_trim_value = s.slow[OTC_SLOW_TRIM_LSB +: 4];
    assign slow_osc_power = 1'b1;
    assign slow_tick_32k = s.slow_tick;

    assign sweep_cfg.interval = s.coarse[OTC_INTERVAL_LSB +: 4];
    assign sweep_cfg.amp_code = s.coarse[OTC_AMP_LSB +: 2];
    assign sweep_cfg.fine = s.fine;
    assign cko_cfg.enable = s.clock_output_control[OTC_CKO_EN_BIT];
    assign cko_cfg.source = otc_src_e'(s.clock_output_control[OTC_CKO_SEL_LSB +: 2]);
    assign cko_cfg.divider = s.clock_output_control[OTC_CKO_DIV_LSB +: 5];

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    // sweep interval field width set here
    otc_sweep #(
        .INTERVAL_W(INTERVAL_W)
    ) i_otc_sweep (
        .clock(clock),
        .rst_n(rst_n),
        .cfg(sweep_cfg),
        .swept_trim_output(swept_trim_output)
    );

    otc_clock_output_control #(
        .DIV_W(DIV_W)
    ) i_otc_clock_output_control (
        .clock(clock),
        .rst_n(rst_n),
        .cfg(cko_cfg),
        .fast_osc_ref(fast_osc_ref),
        .slow_tick_32k(s.slow_tick),
        .clock_out(clock_out)
    );

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_first_cycle;
        req && !s.ack;
    endsequence

    sequence s_answer;
        !avs_waitrequest;
    endsequence

    property p_one_wait;
        @(posedge clock) disable iff (!rst_n)
        s_first_cycle |-> avs_waitrequest ##1 s_answer;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("Bus answer not after one wait cycle.");

    property p_unmapped;
        @(posedge clock) disable iff (!rst_n)
        (avs_req.read && !avs_waitrequest && sel == OTC_REG_NONE) |-> (avs_readdata == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped read returned nonzero.");

    property p_standby;
        @(posedge clock) disable iff (!rst_n)
        (cpu_stop || cpu_sleep) |=> !fast_osc_run;
    endproperty
    a_standby: assert property (p_standby) else $error("Fast oscillator runs in stop or sleep.");

    property p_wake;
        @(posedge clock) disable iff (!rst_n)
        (!cpu_stop && !cpu_sleep) |=> fast_osc_run;
    endproperty
    a_wake: assert property (p_wake) else $error("Fast oscillator did not resume on wake.");

    property p_slow_on;
        @(posedge clock) disable iff (!rst_n)
        (cpu_stop || cpu_sleep) |-> ##1 slow_osc_power [*2];
    endproperty
    a_slow_on: assert property (p_slow_on) else $error("Slow oscillator powered down.");

    property p_slow_reset;
        @(posedge clock) disable iff (!rst_n)
        $rose(rst_n) |-> (!slow_freq_select && slow_osc_trim_value == 4'h8);
    endproperty
    a_slow_reset: assert property (p_slow_reset) else $error("Slow trim reset value wrong.");

    property p_fine_write;
        @(posedge clock) disable iff (!rst_n)
        (wr_take && sel == OTC_REG_FINE && sweep_cfg.interval == 4'h0)
        |=> ##1 (swept_trim_output == $past(avs_req.writedata[7:0], 2));
    endproperty
    a_fine_write: assert property (p_fine_write) else $error("Fine trim write not seen.");

endmodule

// ==== dv/otc_tb_top.sv ====
// Purpose: Self-checking bench for the oscillator trim and clock-out block.
// Assumes: One clock; bus requests wait at least one cycle for waitrequest.
// Notes:   Oscillator inputs toggle each clock, so fast edges come every second cycle.
`timescale 1ns/1ps
module otc_tb_top
    import otc_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    otc_avs_req_s avs_req = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, cpu_stop = 1'b0, cpu_sleep = 1'b0;
    logic fast_osc_ref = 1'b0, slow_osc_base = 1'b0, fast_osc_run, slow_osc_power;
    logic slow_freq_select, slow_tick_32k, clock_out;
    logic [1:0] coarse_range_trim;
    logic [7:0] swept_trim_output;
    logic [3:0] slow_osc_trim_value;
    logic [31:0] rd;
    int failures = 0, tests_run = 0, p;

    otc_top i_otc_top (.clock(clock), .rst_n(rst_n), .avs_req(avs_req),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .cpu_stop(cpu_stop), .cpu_sleep(cpu_sleep), .fast_osc_ref(fast_osc_ref),
        .slow_osc_base(slow_osc_base), .fast_osc_run(fast_osc_run),
        .coarse_range_trim(coarse_range_trim), .swept_trim_output(swept_trim_output),
        .slow_osc_power(slow_osc_power), .slow_freq_select(slow_freq_select),
        .slow_osc_trim_value(slow_osc_trim_value), .slow_tick_32k(slow_tick_32k),
        .clock_out(clock_out));

    // Clock and free-running oscillator levels.
    always #50 clock = ~clock;
    always @(posedge clock) begin
        fast_osc_ref <= ~fast_osc_ref;
        slow_osc_base <= ~slow_osc_base;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic finish_test();
        if (failures == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
            failures++;
        end
    endtask

    // Holds the request until waitrequest is seen low at a rising edge.
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        avs_req <= '{read: !wr, write: wr, address: {idx, 2'b00},
                     writedata: {24'h0, wd}, byteenable: 4'hF};
        @(posedge clock);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            n++;
            @(posedge clock);
        end
        if (n >= 20) begin
            failures++;
            finish_test();
        end
        rd = avs_readdata;
        avs_req <= '0;
        @(posedge clock);
    endtask

    // Cycles between two rising edges of the tick or of the clock output.
    task automatic period(input bit t, output int q);
        logic prev, cur;
        int n, first;
        q = -1;
        first = -1;
        prev = t ? slow_tick_32k : clock_out;
        for (n = 0; n < 300 && q < 0; n++) begin
            @(negedge clock);
            cur = t ? slow_tick_32k : clock_out;
            if (cur === 1'b1 && prev === 1'b0) begin
                if (first < 0) first = n;
                else q = n - first;
            end
            prev = cur;
        end
    endtask

    // Sweep: extremes and repetition after one full period of 4*N*(2A+1).
    task automatic sweep(input logic [3:0] iv, input logic [7:0] f, input logic [7:0] hi,
                         input logic [7:0] lo);
        logic [7:0] s[272];
        logic [7:0] mx, mn;
        int per, k;
        per = 4 * iv * 17;
        bus(1'b1, OTC_IDX_FINE, f);
        bus(1'b1, OTC_IDX_COARSE, {iv, 2'b01, 2'b00});
        mx = 8'h00;
        mn = 8'hFF;
        for (k = 0; k < 2 * per; k++) begin
            @(negedge clock);
            s[k] = swept_trim_output;
            if (s[k] > mx) mx = s[k];
            if (s[k] < mn) mn = s[k];
        end
        check({24'h0, mx}, {24'h0, hi});
        check({24'h0, mn}, {24'h0, lo});
        for (k = 0; k < per; k++) check({24'h0, s[k]}, {24'h0, s[k + per]});
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic regs_and_map();
        bus(1'b0, OTC_IDX_COARSE, 8'h00);
        check(rd, {24'h0, OTC_RST_COARSE});
        bus(1'b0, OTC_IDX_FINE, 8'h00);
        check(rd, {24'h0, OTC_RST_FINE});
        bus(1'b0, OTC_IDX_CLOCK_OUTPUT_CONTROL, 8'h00);
        check(rd, {24'h0, OTC_RST_CLOCK_OUTPUT_CONTROL});
        bus(1'b0, OTC_IDX_SLOW, 8'h00);
        check(rd, 32'h0000_0008);
        bus(1'b1, 16'hA004, 8'h5A);
        bus(1'b0, 16'hA004, 8'h00);
        check(rd, 32'h0000_0000);
        bus(1'b1, OTC_IDX_SWEPT, 8'h11);
        bus(1'b0, OTC_IDX_SWEPT, 8'h00);
        check(rd, 32'h0000_0080);
    endtask

    task automatic fixed_trim_and_slow();
        bus(1'b1, OTC_IDX_COARSE, 8'h03);
        bus(1'b1, OTC_IDX_FINE, 8'h5A);
        repeat (30) @(negedge clock);
        check({30'h0, coarse_range_trim}, 32'h3);
        check({24'h0, swept_trim_output}, 32'h5A);
        period(1'b1, p);
        check(32'(p), 32'd8);
        bus(1'b1, OTC_IDX_SLOW, 8'h1C);
        bus(1'b0, OTC_IDX_SLOW, 8'h00);
        check(rd, 32'h0000_001C);
        check({26'h0, slow_osc_power, slow_freq_select, slow_osc_trim_value}, 32'h3C);
        period(1'b1, p);
        check(32'(p), 32'd16);
        bus(1'b1, OTC_IDX_SLOW, 8'h08);
    endtask

    task automatic standby();
        cpu_stop <= 1'b1;
        repeat (3) @(posedge clock);
        check({31'h0, fast_osc_run}, 32'h0);
        cpu_stop <= 1'b0;
        cpu_sleep <= 1'b1;
        repeat (3) @(posedge clock);
        check({31'h0, fast_osc_run}, 32'h0);
        cpu_sleep <= 1'b0;
        repeat (3) @(posedge clock);
        check({31'h0, fast_osc_run & slow_osc_power}, 32'h1);
    endtask

    task automatic clock_output();
        logic seen;
        int k;
        int exp[4] = '{4, 8, 16, 4};
        for (k = 0; k < 4; k++) begin
            bus(1'b1, OTC_IDX_CLOCK_OUTPUT_CONTROL, 8'h00);
            bus(1'b1, OTC_IDX_CLOCK_OUTPUT_CONTROL, {1'b1, 2'(k), k == 2 ? 5'h01 : 5'h03});
            period(1'b0, p);
            check(32'(p), 32'(exp[k]));
        end
        bus(1'b1, OTC_IDX_CLOCK_OUTPUT_CONTROL, 8'h03);
        seen = 1'b0;
        repeat (20) begin
            @(negedge clock);
            seen = seen | clock_out;
        end
        check({31'h0, seen}, 32'h0);
    endtask

    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        regs_and_map();
        fixed_trim_and_slow();
        standby();
        clock_output();
        sweep(4'h1, 8'h80, 8'h88, 8'h78);
        sweep(4'h2, 8'hFF, 8'hFF, 8'hF7);
        sweep(4'h1, 8'h00, 8'h08, 8'h00);
        finish_test();
    end
endmodule
